// ---- logic/cfbic_pkg.sv ----
// Package of constants and types shared by the CAN configuration block.
package cfbic_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned RESET_WAIT_NS  = 100_000;
  localparam int unsigned RESET_WAIT_CYC = (RESET_WAIT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned WAIT_W         = 12;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_RATE      = 8'h08;
  localparam logic [7:0] ADDR_TIMING    = 8'h0C;
  localparam logic [7:0] ADDR_CODE      = 8'h10;
  localparam logic [7:0] ADDR_MASK      = 8'h14;
  localparam logic [7:0] ADDR_INT_CAUSE = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h1C;
  localparam logic [7:0] ADDR_EFF_TIME  = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_RESET_BIT  = 0;
  localparam int unsigned CTRL_ENABLE_BIT = 1;
  localparam int unsigned STAT_INRST_BIT  = 0;
  localparam int unsigned STAT_RUN_BIT    = 1;
  localparam int unsigned STAT_FAIL_BIT   = 2;
  localparam int unsigned RATE_CUSTOM_BIT = 8;
  localparam int unsigned TIM_BT1_LSB     = 8;
  localparam int unsigned INT_RX          = 0;
  localparam int unsigned INT_TX          = 1;
  localparam int unsigned INT_ERR_WARN    = 2;
  localparam int unsigned INT_OVERRUN     = 3;
  localparam int unsigned INT_WAKEUP      = 4;
  localparam int unsigned INT_BUS_PASSIVE = 5;
  localparam int unsigned INT_ARB_LOST    = 6;
  localparam int unsigned INT_BUS_ERR     = 7;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0]  RATE_RST     = 4'h0;
  localparam logic [3:0]  RATE_CUSTOM  = 4'h0;
  localparam logic [3:0]  RATE_MAX     = 4'hC;
  localparam logic [7:0]  BT_RST       = 8'h00;
  localparam logic [31:0] CODE_RST     = 32'h00000000;
  localparam logic [31:0] MASK_RST     = 32'hFFFFFFFF;
  localparam logic [7:0]  INT_MASK_RST = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  // Bits of the filter word that take part in a compare for each identifier size.
  localparam logic [31:0] STD_USED     = 32'hFFF0FFFF;
  localparam logic [31:0] EXT_USED     = 32'hFFFFFFFC;

  // Preset {timing byte zero, timing byte one}, index = rate value 1..12:
  // 5K 10K 20K 25K 50K 100K 125K 200K 250K 500K 800K 1M. Defaults assume a
  // 16 MHz controller oscillator; entry 0 is never used.
  localparam logic [15:0] PRESET_TIMING [16] = '{
    16'h0000, 16'hBF7F, 16'h311C, 16'h181C, 16'h131C, 16'h091C, 16'h041C,
    16'h031C, 16'h81FA, 16'h011C, 16'h001C, 16'h0016, 16'h0014,
    16'h0000, 16'h0000, 16'h0000};

  typedef enum logic [1:0] {
    ST_IN_RESET = 2'b00,
    ST_ENTERING = 2'b01,
    ST_RUN      = 2'b10
  } cfbic_state_type;

endpackage : cfbic_pkg

// ---- logic/cfbic_rate_preset.sv ----
// Bit-rate selection: preset timing bytes or the user's own pair.
module cfbic_rate_preset
  import cfbic_pkg::*;
(
  input  wire logic [3:0] i_rate,
  input  wire logic [7:0] i_bt0_user,
  input  wire logic [7:0] i_bt1_user,
  output logic      [7:0] o_bt0,
  output logic      [7:0] o_bt1,
  output logic            o_custom
);

  always_comb begin
    o_custom = (i_rate == RATE_CUSTOM);
    if (o_custom) begin
      o_bt0 = i_bt0_user;
      o_bt1 = i_bt1_user;
    end else begin
      o_bt0 = PRESET_TIMING[i_rate][15:8];
      o_bt1 = PRESET_TIMING[i_rate][7:0];
    end
  end

endmodule : cfbic_rate_preset

// ---- logic/cfbic_accept_filter.sv ----
// Acceptance filter: code and mask compare against a received message.
module cfbic_accept_filter
  import cfbic_pkg::*;
(
  input  wire logic [31:0] i_code,
  input  wire logic [31:0] i_mask,
  input  wire logic        i_ext,
  input  wire logic [28:0] i_id,
  input  wire logic        i_rtr,
  input  wire logic [7:0]  i_data0,
  input  wire logic [7:0]  i_data1,
  output logic             o_accept
);

  logic [31:0] target;
  logic [31:0] used;
  logic [31:0] hit;

  // ----------------------------------------------------------------------
  // Compare word layout
  // ----------------------------------------------------------------------
  always_comb begin
    if (i_ext) begin
      target = {i_id, i_rtr, 2'b00};
      used   = EXT_USED;
    end else begin
      target = {i_id[10:0], i_rtr, 4'h0, i_data0, i_data1};
      used   = STD_USED;
    end
  end

  // A set mask bit, or an unused position, always counts as a hit.
  for (genvar gi = 0; gi < 32; gi++) begin : g_bit
    assign hit[gi] = i_mask[gi] | ~used[gi] | (i_code[gi] == target[gi]);
  end

  assign o_accept = &hit;

endmodule : cfbic_accept_filter

// ---- logic/cfbic_top.sv ----
// CAN configuration block: rate, acceptance filter, interrupt causes, AXI4-Lite.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.

// Function
// - Successful receive sets cause 0x01.
// - Successful transmit sets cause 0x02.
// - Other causes each own one bit.
// - Twelve preset bit rates by rate value.
// - Rate zero uses the two user timing bytes.
// - Readback flags user timing when rate zero.
// - Clear mask bit demands code bit match.
// - Standard id: id, rtr at 31:20.
// - Standard id: data bytes at 15:0.
// - Extended id: id 31:3, rtr bit 2.
// - Config needs reset state; else report failure.
module cfbic_top
  import cfbic_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic      [1:0]  o_s_axi_bresp,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic      [31:0] o_s_axi_rdata,
  output logic      [1:0]  o_s_axi_rresp,
  input  wire logic        i_core_idle,
  input  wire logic        i_rx_done,
  input  wire logic        i_rx_ext,
  input  wire logic [28:0] i_rx_id,
  input  wire logic        i_rx_rtr,
  input  wire logic [7:0]  i_rx_data0,
  input  wire logic [7:0]  i_rx_data1,
  input  wire logic        i_tx_done,
  input  wire logic        i_err_warn,
  input  wire logic        i_overrun,
  input  wire logic        i_wakeup,
  input  wire logic        i_bus_passive,
  input  wire logic        i_arb_lost,
  input  wire logic        i_bus_err,
  output logic             o_rx_accept,
  output logic      [7:0]  o_bus_timing_byte_zero,
  output logic      [7:0]  o_bus_timing_byte_one,
  output logic             o_core_reset,
  output logic             o_core_run,
  output logic             o_irq
);

  import cfbic_pkg::*;

  typedef struct packed {
    cfbic_state_type    st;
    logic [WAIT_W-1:0]  wait_cnt;
    logic               rst_req;
    logic               enable;
    logic               reset_fail;
    logic [3:0]         rate;
    logic [7:0]         bt0_user;
    logic [7:0]         bt1_user;
    logic [31:0]        acceptance_code_word;
    logic [31:0]        acceptance_mask_word;
    logic [7:0]         interrupt_cause_byte;
    logic [7:0]         int_mask;
    logic [7:0]         eff_bt0;
    logic [7:0]         eff_bt1;
    logic               rx_accept;
    logic               aw_held;
    logic [7:0]         awaddr;
    logic               w_held;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } cfbic_regs_type;

  cfbic_regs_type s;
  cfbic_regs_type next_s;

  logic       rx_hit;
  logic       custom;
  logic [7:0] pre_bt0;
  logic [7:0] pre_bt1;
  logic       wr_go;
  logic       wr_cfg;
  logic [7:0] events;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  cfbic_accept_filter u_filter (
    .i_code   (s.acceptance_code_word),
    .i_mask   (s.acceptance_mask_word),
    .i_ext    (i_rx_ext),
    .i_id     (i_rx_id),
    .i_rtr    (i_rx_rtr),
    .i_data0  (i_rx_data0),
    .i_data1  (i_rx_data1),
    .o_accept (rx_hit)
  );

  cfbic_rate_preset u_rate (
    .i_rate     (s.rate),
    .i_bt0_user (s.bt0_user),
    .i_bt1_user (s.bt1_user),
    .o_bt0      (pre_bt0),
    .o_bt1      (pre_bt1),
    .o_custom   (custom)
  );

  // ----------------------------------------------------------------------
  // Bus handshakes and outputs
  // ----------------------------------------------------------------------
  assign o_s_axi_awready = i_ce & ~s.aw_held & ~s.bvalid;
  assign o_s_axi_wready  = i_ce & ~s.w_held & ~s.bvalid;
  assign o_s_axi_arready = i_ce & ~s.rvalid;
  assign o_s_axi_bvalid  = s.bvalid;
  assign o_s_axi_bresp   = s.bresp;
  assign o_s_axi_rvalid  = s.rvalid;
  assign o_s_axi_rdata   = s.rdata;
  assign o_s_axi_rresp   = s.rresp;
  assign o_rx_accept     = s.rx_accept;
  assign o_bus_timing_byte_zero = s.eff_bt0;
  assign o_bus_timing_byte_one  = s.eff_bt1;
  assign o_core_reset    = (s.st == ST_IN_RESET);
  assign o_core_run      = (s.st == ST_RUN) & s.enable;
  assign o_irq           = |(s.interrupt_cause_byte & s.int_mask);

  assign wr_go  = s.aw_held & s.w_held & ~s.bvalid;
  assign wr_cfg = (s.awaddr == ADDR_RATE) | (s.awaddr == ADDR_TIMING) |
                  (s.awaddr == ADDR_CODE) | (s.awaddr == ADDR_MASK);

  // Core events only count while the controller runs.
  always_comb begin
    events               = 8'h00;
    events[INT_RX]       = i_rx_done & rx_hit;
    events[INT_TX]       = i_tx_done;
    events[INT_ERR_WARN] = i_err_warn;
    events[INT_OVERRUN]  = i_overrun;
    events[INT_WAKEUP]   = i_wakeup;
    events[INT_BUS_PASSIVE] = i_bus_passive;
    events[INT_ARB_LOST] = i_arb_lost;
    events[INT_BUS_ERR]  = i_bus_err;
    if (!o_core_run) begin
      events = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0]  cause_clr;
    logic        fail_clr;
    logic        fail_set;
    logic [31:0] wv;
    cause_clr = 8'h00;
    fail_clr  = 1'b0;
    fail_set  = 1'b0;
    wv        = merge(32'h00000000, s.wdata, s.wstrb);
    next_s    = s;
    next_s.rx_accept = o_core_run & i_rx_done & rx_hit;
    next_s.eff_bt0   = pre_bt0;
    next_s.eff_bt1   = pre_bt1;

    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = i_s_axi_wdata;
      next_s.wstrb  = i_s_axi_wstrb;
    end
    if (s.bvalid && i_s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && i_s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Filter and rate may only change while the controller is held in reset.
    if (wr_go) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (wr_cfg && s.st != ST_IN_RESET) begin
        next_s.bresp = RESP_SLVERR;
        fail_set     = 1'b1;
      end else begin
        case (s.awaddr)
          ADDR_CTRL: begin
            if (s.wstrb[0]) begin
              next_s.rst_req = s.wdata[CTRL_RESET_BIT];
              next_s.enable  = s.wdata[CTRL_ENABLE_BIT];
            end
          end
          ADDR_STATUS: begin
            fail_clr = wv[STAT_FAIL_BIT];
          end
          ADDR_RATE: begin
            if (s.wstrb[0] && s.wdata[3:0] <= RATE_MAX) begin
              next_s.rate = s.wdata[3:0];
            end else if (s.wstrb[0]) begin
              next_s.bresp = RESP_SLVERR;
            end
          end
          ADDR_TIMING: begin
            if (s.wstrb[0]) begin
              next_s.bt0_user = s.wdata[7:0];
            end
            if (s.wstrb[1]) begin
              next_s.bt1_user = s.wdata[TIM_BT1_LSB +: 8];
            end
          end
          ADDR_CODE: begin
            next_s.acceptance_code_word = merge(s.acceptance_code_word, s.wdata, s.wstrb);
          end
          ADDR_MASK: begin
            next_s.acceptance_mask_word = merge(s.acceptance_mask_word, s.wdata, s.wstrb);
          end
          ADDR_INT_CAUSE: begin
            cause_clr = wv[7:0];
          end
          ADDR_INT_MASK: begin
            if (s.wstrb[0]) begin
              next_s.int_mask = s.wdata[7:0];
            end
          end
          ADDR_EFF_TIME: begin
          end
          default: begin
            next_s.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    if (i_s_axi_arvalid && o_s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h00000000;
      case (i_s_axi_araddr)
        ADDR_CTRL: begin
          next_s.rdata[CTRL_RESET_BIT]  = s.rst_req;
          next_s.rdata[CTRL_ENABLE_BIT] = s.enable;
        end
        ADDR_STATUS: begin
          next_s.rdata[STAT_INRST_BIT] = o_core_reset;
          next_s.rdata[STAT_RUN_BIT]   = o_core_run;
          next_s.rdata[STAT_FAIL_BIT]  = s.reset_fail;
        end
        ADDR_RATE: begin
          next_s.rdata[3:0]             = s.rate;
          next_s.rdata[RATE_CUSTOM_BIT] = custom;
        end
        ADDR_TIMING:    next_s.rdata[15:0] = {s.bt1_user, s.bt0_user};
        ADDR_CODE:      next_s.rdata = s.acceptance_code_word;
        ADDR_MASK:      next_s.rdata = s.acceptance_mask_word;
        ADDR_INT_CAUSE: next_s.rdata[7:0] = s.interrupt_cause_byte;
        ADDR_INT_MASK:  next_s.rdata[7:0] = s.int_mask;
        ADDR_EFF_TIME:  next_s.rdata[15:0] = {s.eff_bt1, s.eff_bt0};
        default:        next_s.rresp = RESP_SLVERR;
      endcase
    end

    // Entering reset waits for the core to go idle; a stuck core times out.
    case (s.st)
      ST_IN_RESET: begin
        if (!s.rst_req) begin
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.rst_req) begin
          next_s.st       = ST_ENTERING;
          next_s.wait_cnt = '0;
        end
      end
      ST_ENTERING: begin
        if (i_core_idle) begin
          next_s.st = ST_IN_RESET;
        end else if (s.wait_cnt == WAIT_W'(RESET_WAIT_CYC - 1)) begin
          next_s.st      = ST_RUN;
          next_s.rst_req = 1'b0;
          fail_set       = 1'b1;
        end else begin
          next_s.wait_cnt = s.wait_cnt + 1'b1;
        end
      end
      default: begin
        next_s.st = ST_IN_RESET;
      end
    endcase

    // New events win over a clear in the same cycle.
    next_s.interrupt_cause_byte = (s.interrupt_cause_byte & ~cause_clr) | events;
    next_s.reset_fail = (s.reset_fail & ~fail_clr) | fail_set;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s                      <= '0;
      s.st                   <= ST_IN_RESET;
      s.rst_req              <= 1'b1;
      s.rate                 <= RATE_RST;
      s.bt0_user             <= BT_RST;
      s.bt1_user             <= BT_RST;
      s.acceptance_code_word <= CODE_RST;
      s.acceptance_mask_word <= MASK_RST;
      s.int_mask             <= INT_MASK_RST;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_rx_cause: assert property (i_ce && o_core_run && i_rx_done && rx_hit
    |=> s.interrupt_cause_byte[INT_RX] && o_rx_accept) else $error("rx cause lost");
  a_tx_cause: assert property (i_ce && o_core_run && i_tx_done
    |=> s.interrupt_cause_byte[INT_TX]) else $error("tx cause lost");
  a_bus_err_cause: assert property (i_ce && o_core_run && i_bus_err
    |=> s.interrupt_cause_byte[INT_BUS_ERR]) else $error("bus error cause lost");
  a_preset_timing: assert property (i_ce && s.rate != RATE_CUSTOM
    |=> o_bus_timing_byte_zero == PRESET_TIMING[$past(s.rate)][15:8])
    else $error("preset timing wrong");
  a_custom_timing: assert property (i_ce && s.rate == RATE_CUSTOM
    |=> o_bus_timing_byte_one == $past(s.bt1_user)) else $error("user timing not used");
  a_custom_flag: assert property (o_s_axi_arready && i_s_axi_arvalid
    && i_s_axi_araddr == ADDR_RATE
    |=> o_s_axi_rdata[RATE_CUSTOM_BIT] == ($past(s.rate) == RATE_CUSTOM))
    else $error("custom flag wrong");
  a_ext_accept: assert property (i_ce && o_core_run && i_rx_done && i_rx_ext
    && ((s.acceptance_code_word ^ {i_rx_id, i_rx_rtr, 2'b00}) & ~s.acceptance_mask_word
        & EXT_USED) == 32'h00000000 |=> o_rx_accept) else $error("ext match dropped");
  a_std_reject: assert property (i_ce && i_rx_done && !i_rx_ext
    && ((s.acceptance_code_word ^ {i_rx_id[10:0], i_rx_rtr, 4'h0, i_rx_data0, i_rx_data1})
        & ~s.acceptance_mask_word & STD_USED) != 32'h00000000 |=> !o_rx_accept)
    else $error("std mismatch accepted");
  a_cfg_refused: assert property (i_ce && wr_go && wr_cfg && s.st != ST_IN_RESET
    |=> s.reset_fail && o_s_axi_bresp == RESP_SLVERR && $stable(s.acceptance_code_word))
    else $error("config change outside reset");
  a_reset_timeout: assert property (i_ce && s.st == ST_ENTERING && !i_core_idle
    && s.wait_cnt == WAIT_W'(RESET_WAIT_CYC - 1) |=> s.reset_fail && s.st == ST_RUN)
    else $error("reset timeout not reported");

  c_rx_accept:  cover property (o_rx_accept);
  c_timeout:    cover property ($rose(s.reset_fail));
  c_irq:        cover property ($rose(o_irq));
  c_enter_rst:  cover property (s.st == ST_ENTERING ##1 s.st == ST_IN_RESET);

endmodule : cfbic_top

// ---- dv/cfbic_core_model.sv ----
// Behavioural model of the protocol core that faces the configuration block.
module cfbic_core_model
(
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_ev,
  input  wire logic        i_idle,
  input  wire logic        i_ext,
  input  wire logic [31:0] i_word,
  output logic             o_idle,
  output logic      [7:0]  o_ev,
  output logic             o_ext,
  output logic      [28:0] o_id,
  output logic             o_rtr,
  output logic      [7:0]  o_d0,
  output logic      [7:0]  o_d1
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {o_idle, o_ev, o_ext, o_id, o_rtr, o_d0, o_d1} = {1'b1, 55'h0};

  always @(posedge i_clk) begin
    o_idle <= i_idle;
    o_ev   <= i_ev;
    if (i_ev[0]) begin
      o_ext <= i_ext;
      o_id  <= i_ext ? i_word[31:3] : {18'h0, i_word[31:21]};
      o_rtr <= i_ext ? i_word[2] : i_word[20];
      {o_d0, o_d1} <= i_word[15:0];
    end else begin
      // Fields mean nothing without the strobe, so they churn to expose misuse.
      {o_ext, o_id, o_rtr, o_d0, o_d1} <= ~{o_ext, o_id, o_rtr, o_d0, o_d1};
    end
  end
endmodule : cfbic_core_model

// ---- dv/can_filter_baud_irq_config_bench.sv ----
// Self-checking bench for the CAN configuration block.
module can_filter_baud_irq_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfbic_pkg::*;

  logic        i_clk_sys = 0, i_rst_n = 0, idle = 1, ext = 0;
  logic        i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic        i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [7:0]  i_s_axi_awaddr = '0, i_s_axi_araddr = '0, ev = '0;
  logic [31:0] i_s_axi_wdata = '0, word = '0, o_s_axi_rdata;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  wire         i_core_idle, i_rx_done, i_rx_ext, i_rx_rtr, i_tx_done, i_err_warn, i_overrun;
  wire         i_wakeup, i_bus_passive, i_arb_lost, i_bus_err, o_rx_accept;
  logic        o_core_reset, o_core_run, o_irq;
  logic [28:0] i_rx_id;
  logic [7:0]  i_rx_data0, i_rx_data1, o_bus_timing_byte_zero, o_bus_timing_byte_one;
  int          mismatches = 0, checks = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  cfbic_top i_dut (
    .i_clk_sys, .i_rst_n, .i_ce(1'b1), .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
    .i_s_axi_awprot(3'h0), .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata,
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid,
    .o_s_axi_arready, .i_s_axi_araddr, .i_s_axi_arprot(3'h0), .o_s_axi_rvalid,
    .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .i_core_idle, .i_rx_done, .i_rx_ext,
    .i_rx_id, .i_rx_rtr, .i_rx_data0, .i_rx_data1, .i_tx_done, .i_err_warn, .i_overrun,
    .i_wakeup, .i_bus_passive, .i_arb_lost, .i_bus_err, .o_rx_accept, .o_bus_timing_byte_zero,
    .o_bus_timing_byte_one, .o_core_reset, .o_core_run, .o_irq);

  cfbic_core_model i_core (.i_clk(i_clk_sys), .i_ev(ev), .i_idle(idle), .i_ext(ext),
    .i_word(word), .o_idle(i_core_idle), .o_ev({i_bus_err, i_arb_lost, i_bus_passive,
    i_wakeup, i_overrun, i_err_warn, i_tx_done, i_rx_done}), .o_ext(i_rx_ext),
    .o_id(i_rx_id), .o_rtr(i_rx_rtr), .o_d0(i_rx_data0), .o_d1(i_rx_data1));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Handshakes are judged at the falling edge, where nothing is in motion.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw;
    i_s_axi_awaddr  <= a;
    i_s_axi_wdata   <= d;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid  <= 1;
    i_s_axi_bready  <= 1;
    ha = 0;
    hw = 0;
    do begin
      @(negedge i_clk_sys);
      ha = ha | (i_s_axi_awvalid & o_s_axi_awready);
      hw = hw | (i_s_axi_wvalid & o_s_axi_wready);
      @(posedge i_clk_sys);
      if (ha) i_s_axi_awvalid <= 0;
      if (hw) i_s_axi_wvalid <= 0;
    end while (!(ha && hw));
    do @(negedge i_clk_sys); while (!o_s_axi_bvalid);
    chk(o_s_axi_bresp, er);
    // Response ready stays high, so back-to-back calls never drive it twice in one step.
    @(posedge i_clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    i_s_axi_araddr  <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready  <= 1;
    do @(negedge i_clk_sys); while (!o_s_axi_arready);
    @(posedge i_clk_sys);
    i_s_axi_arvalid <= 0;
    do @(negedge i_clk_sys); while (!o_s_axi_rvalid);
    chk(o_s_axi_rdata, e);
    chk(o_s_axi_rresp, er);
    @(posedge i_clk_sys);
  endtask : rd

  task automatic pulse(input logic [7:0] e, output logic acc);
    ev <= e;
    @(posedge i_clk_sys);
    ev <= 0;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    acc = o_rx_accept;
    @(posedge i_clk_sys);
  endtask : pulse

  function automatic logic exp_acc(input logic [31:0] c, input logic [31:0] m, input logic x,
                                   input logic [31:0] w);
    logic [31:0] u;
    u = x ? 32'hFFFFFFFC : 32'hFFF0FFFF;
    return ((w ^ c) & ~m & u) == 32'h0;
  endfunction : exp_acc

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin : watchdog
    #(20_000 * 40);
    $display("ERROR at %0t: timeout", $time);
    mismatches++;
    results();
  end

  initial begin : main
    logic [31:0] c, m, t;
    logic        a;
    void'($urandom(28));
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1;
    @(posedge i_clk_sys);
    chk({o_core_reset, o_core_run, o_irq, o_bus_timing_byte_zero, o_bus_timing_byte_one},
        19'h40000);
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_RATE, 32'h100, RESP_OKAY);
    rd(ADDR_MASK, 32'hFFFFFFFF, RESP_OKAY);
    rd(8'h24, 32'h0, RESP_SLVERR);
    for (int k = 1; k <= 13; k++) begin
      wr(ADDR_RATE, k, k < 13 ? RESP_OKAY : RESP_SLVERR);
      rd(ADDR_RATE, k < 13 ? k : 12, RESP_OKAY);
      t = {16'h0, PRESET_TIMING[k < 13 ? k : 12]};
      rd(ADDR_EFF_TIME, {16'h0, t[7:0], t[15:8]}, RESP_OKAY);
      chk({o_bus_timing_byte_zero, o_bus_timing_byte_one}, t);
    end
    t = $urandom;
    wr(ADDR_RATE, 0, RESP_OKAY);
    wr(ADDR_TIMING, t, RESP_OKAY);
    rd(ADDR_RATE, 32'h100, RESP_OKAY);
    chk({o_bus_timing_byte_one, o_bus_timing_byte_zero}, t[15:0]);
    wr(ADDR_CTRL, 2, RESP_OKAY);
    wr(ADDR_RATE, 1, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h6, RESP_OKAY);
    wr(ADDR_STATUS, 4, RESP_OKAY);
    idle <= 0;
    wr(ADDR_CTRL, 3, RESP_OKAY);
    repeat (RESET_WAIT_CYC + 20) @(posedge i_clk_sys);
    rd(ADDR_STATUS, 32'h6, RESP_OKAY);
    idle <= 1;
    wr(ADDR_STATUS, 4, RESP_OKAY);
    wr(ADDR_INT_MASK, 32'hFF, RESP_OKAY);
    for (int k = 0; k < 9; k++) begin
      t = k < 8 ? 32'h1 << k : 32'hFF;
      pulse(t[7:0], a);
      rd(ADDR_INT_CAUSE, t, RESP_OKAY);
      chk(o_irq, 1);
      wr(ADDR_INT_MASK, ~t & 32'hFF, RESP_OKAY);
      chk(o_irq, 0);
      wr(ADDR_INT_MASK, 32'hFF, RESP_OKAY);
      wr(ADDR_INT_CAUSE, t, RESP_OKAY);
      rd(ADDR_INT_CAUSE, 0, RESP_OKAY);
    end
    for (int i = 0; i < 40; i++) begin
      c = i ? $urandom : 32'h000000A0;
      m = i ? $urandom & $urandom : 32'hFFFFFF1F;
      wr(ADDR_CTRL, 1, RESP_OKAY);
      wr(ADDR_CODE, c, RESP_OKAY);
      wr(ADDR_MASK, m, RESP_OKAY);
      wr(ADDR_CTRL, 2, RESP_OKAY);
      for (int j = 0; j < 4; j++) begin
        t = c ^ (m & $urandom);
        if (j > 1) t ^= 32'h1 << ($urandom % 32);
        ext  <= j[0];
        word <= t;
        pulse(8'h1, a);
        chk(a, exp_acc(c, m, j[0], t));
      end
    end
    results();
  end
endmodule : can_filter_baud_irq_config_bench
